// ===== rtl/sio_change_det.sv
// Change-of-state detector for the port pins.
// Assumes pin levels arrive already registered in the system clock.
module sio_change_det
	import sio_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// Levels and enables
	input  wire logic [W-1:0] level_in,
	input  wire logic [W-1:0] enable_in,
	// Request
	output logic              change_irq_out
);

	logic [W-1:0] prev_r;
	logic         primed_r;
	logic [W-1:0] diff;

	// ----------------------------------------------------------------
	// Per-pin compare against last captured level
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < W; i++) begin : g_pin
			assign diff[i] = (level_in[i] ^ prev_r[i]) & enable_in[i];
		end
	endgenerate

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prev_r <= '0;
		end else begin
			prev_r <= level_in;
		end
	end

	// First cycle only captures, so reset itself is not seen as a change
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			primed_r <= 1'b0;
		end else begin
			primed_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			change_irq_out <= 1'b0;
		end else begin
			change_irq_out <= primed_r & (|diff);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_cn_req;
		@(posedge clk_in) disable iff (rst_in)
		(primed_r && |((level_in ^ prev_r) & enable_in)) |=> change_irq_out;
	endproperty
	a_cn_req: assert property (p_cn_req) else $error("change not requested");

	property p_cn_quiet;
		@(posedge clk_in) disable iff (rst_in)
		(((level_in ^ prev_r) & enable_in) == '0) |=> !change_irq_out;
	endproperty
	a_cn_quiet: assert property (p_cn_quiet) else $error("spurious change request");

endmodule

// ===== rtl/sio_pkg.sv
// Constants for the shared I/O port with change notification.
// Assumes a 16-bit register port and one system clock.
package sio_pkg;

	// ----------------------------------------------------------------
	// Register offsets (word index on the register port)
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 16;
	localparam logic [3:0]  OFS_DIR         = 4'h0;
	localparam logic [3:0]  OFS_LEVEL       = 4'h1;
	localparam logic [3:0]  OFS_LATCH       = 4'h2;
	localparam logic [3:0]  OFS_ODRAIN      = 4'h3;
	localparam logic [3:0]  OFS_ANALOG      = 4'h4;
	localparam logic [3:0]  OFS_CN_EN       = 4'h5;
	localparam logic [3:0]  OFS_PULLUP      = 4'h6;
	localparam logic [3:0]  OFS_PULLDN      = 4'h7;
	localparam logic [3:0]  OFS_CN_STAT     = 4'h8;

	// ----------------------------------------------------------------
	// Reset values and chip-wide figures
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_DIR         = 16'hffff;
	localparam logic [15:0] RST_ZERO        = 16'h0000;
	localparam logic [15:0] IMPL_ALL        = 16'hffff;
	localparam int          CN_MAX_PINS     = 81;
	localparam int          CN_EN_REGS      = 6;
	localparam int          CN_STAT_BIT     = 0;

endpackage

// ===== rtl/sio_port.sv
// Shared parallel I/O port: direction, latch, pin read, peripheral
// override, open-drain, analog masking, change notification.
// Assumes pin and peripheral inputs are synchronous to clk_in.
//
// Notes on behaviour
// - Active peripheral drive turns off the port driver; pin still readable.
// - Enabled but idle peripheral lets the port drive the pin.
// - Port-driven level never reaches the sharing peripheral input.
// - Direction bit one means input, zero means output.
// - Every pin comes up as input after reset.
// - Latch register reads back the latch, writes update it.
// - Level register reads pins, writes go to the latch.
// - Unimplemented bits read zero in latch, direction and level.
// - Open-drain bit makes the pin drive low only.
// - Analog-configured pins read low from the level register.
// - Enabled pin change raises the change request.
// - Up to 81 pins chip-wide; this port holds its share.
// - Each pin has its own change interrupt enable bit.
// - Each pin has separate weak pull-up and pull-down enables.
// - Input-only peripheral leaves the port sole output owner.
//
// Decided for this implementation: the register addresses and the strobed register port.
module sio_port
	import sio_pkg::*;
#(
	parameter int          W    = 16,
	parameter logic [15:0] IMPL = IMPL_ALL
) (
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	// Register port
	input  wire logic [ADDR_W-1:0]    reg_addr_in,
	input  wire logic [DATA_W-1:0]    reg_wdata_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	output logic      [DATA_W-1:0]    reg_rdata_out,
	// Pins
	input  wire logic [W-1:0]         pin_in,
	output logic      [W-1:0]         pin_out,
	output logic      [W-1:0]         pin_oe_out,
	output logic      [W-1:0]         pullup_en_out,
	output logic      [W-1:0]         pulldown_en_out,
	// Sharing peripheral
	input  wire logic [W-1:0]         periph_en_in,
	input  wire logic [W-1:0]         periph_drive_in,
	input  wire logic [W-1:0]         periph_data_in,
	input  wire logic [W-1:0]         periph_in_only_in,
	output logic      [W-1:0]         periph_rx_out,
	// Change notification
	output logic                      change_irq_out
);

	import sio_pkg::*;

	localparam logic [W-1:0] IMPL_W = IMPL[W-1:0];

	logic [W-1:0] dir_r;
	logic [W-1:0] latch_r;
	logic [W-1:0] odrain_r;
	logic [W-1:0] analog_r;
	logic [W-1:0] cn_en_r;
	logic [W-1:0] level_r;
	logic         cn_seen_r;
	logic [W-1:0] periph_owns;
	logic [W-1:0] drv_data;
	logic [W-1:0] drv_en;
	logic [W-1:0] pin_out_nxt;
	logic [W-1:0] pin_oe_nxt;
	logic [DATA_W-1:0] rdata_nxt;
	logic         cn_req;

	// Write hit on one register
	function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
		return reg_wr_in && (reg_addr_in == ofs);
	endfunction

	// Place a port-wide vector into the data word
	function automatic logic [DATA_W-1:0] to_word(input logic [W-1:0] v);
		logic [DATA_W-1:0] w;
		w = '0;
		w[W-1:0] = v;
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dir_r <= RST_DIR[W-1:0] & IMPL_W;
		end else if (wr_hit(OFS_DIR)) begin
			dir_r <= reg_wdata_in[W-1:0] & IMPL_W;
		end
	end

	// Both the latch and the level offsets land in the latch
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			latch_r <= RST_ZERO[W-1:0];
		end else if (wr_hit(OFS_LATCH) || wr_hit(OFS_LEVEL)) begin
			latch_r <= reg_wdata_in[W-1:0] & IMPL_W;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			odrain_r <= RST_ZERO[W-1:0];
		end else if (wr_hit(OFS_ODRAIN)) begin
			odrain_r <= reg_wdata_in[W-1:0];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			analog_r <= RST_ZERO[W-1:0];
		end else if (wr_hit(OFS_ANALOG)) begin
			analog_r <= reg_wdata_in[W-1:0];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cn_en_r <= RST_ZERO[W-1:0];
		end else if (wr_hit(OFS_CN_EN)) begin
			cn_en_r <= reg_wdata_in[W-1:0];
		end
	end

	// Pull controls go straight out to the pad
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pullup_en_out   <= RST_ZERO[W-1:0];
			pulldown_en_out <= RST_ZERO[W-1:0];
		end else begin
			if (wr_hit(OFS_PULLUP)) begin
				pullup_en_out <= reg_wdata_in[W-1:0];
			end
			if (wr_hit(OFS_PULLDN)) begin
				pulldown_en_out <= reg_wdata_in[W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			level_r <= RST_ZERO[W-1:0];
		end else begin
			level_r <= pin_in & IMPL_W;
		end
	end

	// ----------------------------------------------------------------
	// Output ownership and drivers
	// ----------------------------------------------------------------
	// Input-only peripherals never claim the driver
	assign periph_owns = periph_en_in & periph_drive_in & ~periph_in_only_in;

	always_comb begin
		drv_data = (periph_owns & periph_data_in) | (~periph_owns & latch_r);
		drv_en   = periph_owns | (~periph_owns & ~dir_r);
		// Open drain: only a low is driven, a high floats
		pin_out_nxt = drv_data & ~odrain_r;
		pin_oe_nxt  = drv_en & ~(odrain_r & drv_data) & IMPL_W;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_out    <= RST_ZERO[W-1:0];
			pin_oe_out <= RST_ZERO[W-1:0];
		end else begin
			pin_out    <= pin_out_nxt;
			pin_oe_out <= pin_oe_nxt;
		end
	end

	// Bits the port itself drives are cut off from the peripheral,
	// an open-drain high included, since that level is still the port's
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			periph_rx_out <= RST_ZERO[W-1:0];
		end else begin
			periph_rx_out <= pin_in & ~(drv_en & ~periph_owns) & ~analog_r;
		end
	end

	// ----------------------------------------------------------------
	// Change notification
	// ----------------------------------------------------------------
	// Limitation: runs on clk_in, so a stopped clock also stops detection
	sio_change_det #(
		.W (W)
	) u_det (
		.clk_in         (clk_in),
		.rst_in         (rst_in),
		.level_in       (level_r),
		.enable_in      (cn_en_r),
		.change_irq_out (cn_req)
	);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			change_irq_out <= 1'b0;
		end else begin
			change_irq_out <= cn_req;
		end
	end

	// Sticky status: a new request wins over a clear in the same cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cn_seen_r <= 1'b0;
		end else if (cn_req) begin
			cn_seen_r <= 1'b1;
		end else if (wr_hit(OFS_CN_STAT) && reg_wdata_in[CN_STAT_BIT]) begin
			cn_seen_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------------------------------
	always_comb begin
		rdata_nxt = '0;
		case (reg_addr_in)
			OFS_DIR:     rdata_nxt = to_word(dir_r);
			OFS_LEVEL:   rdata_nxt = to_word(level_r & ~analog_r);
			OFS_LATCH:   rdata_nxt = to_word(latch_r);
			OFS_ODRAIN:  rdata_nxt = to_word(odrain_r);
			OFS_ANALOG:  rdata_nxt = to_word(analog_r);
			OFS_CN_EN:   rdata_nxt = to_word(cn_en_r);
			OFS_PULLUP:  rdata_nxt = to_word(pullup_en_out);
			OFS_PULLDN:  rdata_nxt = to_word(pulldown_en_out);
			OFS_CN_STAT: rdata_nxt[CN_STAT_BIT] = cn_seen_r;
			default:     rdata_nxt = '0;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_nxt;
		end else begin
			reg_rdata_out <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_wr_level;
		reg_wr_in && reg_addr_in == OFS_LEVEL;
	endsequence

	sequence s_rd_latch;
		reg_rd_in && reg_addr_in == OFS_LATCH;
	endsequence

	sequence s_wr_pullup;
		reg_wr_in && reg_addr_in == OFS_PULLUP;
	endsequence

	property p_dir_reset;
		@(posedge clk_in) $fell(rst_in) |-> dir_r == (RST_DIR[W-1:0] & IMPL_W);
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("pins not inputs");

	property p_periph_drive;
		@(posedge clk_in) disable iff (rst_in)
		1'b1 |=> (pin_oe_out & $past(periph_owns) & ~$past(odrain_r) & IMPL_W)
			== ($past(periph_owns) & ~$past(odrain_r) & IMPL_W);
	endproperty
	a_periph_drive: assert property (p_periph_drive) else $error("peripheral lost pin");

	property p_port_drive;
		@(posedge clk_in) disable iff (rst_in)
		1'b1 |=> ((pin_out ^ $past(latch_r)) & ~$past(periph_owns)
			& ~$past(dir_r) & ~$past(odrain_r)) == '0;
	endproperty
	a_port_drive: assert property (p_port_drive) else $error("port level wrong");

	property p_dir_in;
		@(posedge clk_in) disable iff (rst_in)
		1'b1 |=> (pin_oe_out & $past(dir_r) & ~$past(periph_owns)) == '0;
	endproperty
	a_dir_in: assert property (p_dir_in) else $error("input pin driven");

	property p_loop;
		@(posedge clk_in) disable iff (rst_in)
		1'b1 |=> (periph_rx_out & ~$past(dir_r) & ~$past(periph_owns)) == '0;
	endproperty
	a_loop: assert property (p_loop) else $error("port looped into peripheral");

	property p_latch_read;
		@(posedge clk_in) disable iff (rst_in)
		s_rd_latch |=> reg_rdata_out == to_word($past(latch_r));
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("latch readback wrong");

	property p_level_write;
		@(posedge clk_in) disable iff (rst_in)
		s_wr_level |=> latch_r == ($past(reg_wdata_in[W-1:0]) & IMPL_W);
	endproperty
	a_level_write: assert property (p_level_write) else $error("level write missed");

	property p_unimpl;
		@(posedge clk_in) disable iff (rst_in)
		((pin_oe_out | dir_r | latch_r | level_r) & ~IMPL_W) == '0;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit active");

	property p_odrain;
		@(posedge clk_in) disable iff (rst_in)
		1'b1 |=> (pin_out & $past(odrain_r)) == '0;
	endproperty
	a_odrain: assert property (p_odrain) else $error("open drain drove high");

	property p_analog;
		@(posedge clk_in) disable iff (rst_in)
		(reg_rd_in && reg_addr_in == OFS_LEVEL)
			|=> (reg_rdata_out[W-1:0] & $past(analog_r)) == '0;
	endproperty
	a_analog: assert property (p_analog) else $error("analog pin read high");

	property p_cn_out;
		@(posedge clk_in) disable iff (rst_in)
		cn_req |=> change_irq_out && cn_seen_r;
	endproperty
	a_cn_out: assert property (p_cn_out) else $error("change request lost");

	property p_cn_set_wins;
		@(posedge clk_in) disable iff (rst_in)
		(cn_req && wr_hit(OFS_CN_STAT)) |=> cn_seen_r;
	endproperty
	a_cn_set_wins: assert property (p_cn_set_wins) else $error("clear beat new change");

	property p_pullup_write;
		@(posedge clk_in) disable iff (rst_in)
		s_wr_pullup |=> pullup_en_out == $past(reg_wdata_in[W-1:0]);
	endproperty
	a_pullup_write: assert property (p_pullup_write) else $error("pull-up enable not taken");

	property p_in_only;
		@(posedge clk_in) disable iff (rst_in)
		1'b1 |=> ((pin_out ^ $past(latch_r)) & $past(periph_in_only_in)
			& ~$past(odrain_r)) == '0;
	endproperty
	a_in_only: assert property (p_in_only) else $error("input-only pin not port driven");

endmodule

// ===== test/sio_pin_model.sv
// External circuitry on the port pads: pulls and a driver.
// Assumes pad controls come straight from the port under test.
module sio_pin_model (
	// Pad side of the port
	input  wire logic        clk_in,
	input  wire logic [15:0] out_in,
	input  wire logic [15:0] oe_in,
	input  wire logic [15:0] pu_in,
	input  wire logic [15:0] pd_in,
	// External driver
	input  wire logic [15:0] ext_in,
	input  wire logic [15:0] ext_en_in,
	output logic      [15:0] level_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] last_r;
	// Floating pads flip, so a stale level never reads as valid
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (oe_in[i])
				level_out[i] = out_in[i];
			else if (ext_en_in[i])
				level_out[i] = ext_in[i];
			else if (pu_in[i] || pd_in[i])
				level_out[i] = pu_in[i];
			else
				level_out[i] = ~last_r[i];
		end
	end
	always_ff @(posedge clk_in) begin
		last_r <= level_out;
	end
endmodule

// ===== test/tb_sio_port.sv
// Self-checking bench for the shared I/O port.
// Assumes a pin model on the pads and bit 15 left unimplemented.
module tb_sio_port
	import sio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] IMP = 16'h7fff;
	logic        clk_in, rst_in, reg_wr, reg_rd, irq;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, pin_lvl, pin_o, pin_oe, pu_o, pd_o, prx;
	logic [15:0] pen, pdrv, pdat, parallel_io, ext, ext_en, dir, lat, od, an, pu, pd, v, own, xoe, xpin;
	int          fail_count, n_compared, seed, cyc, n;

	sio_port #(.W(16), .IMPL(IMP)) uut (.clk_in(clk_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .pin_in(pin_lvl),
		.pin_out(pin_o), .pin_oe_out(pin_oe), .pullup_en_out(pu_o),
		.pulldown_en_out(pd_o), .periph_en_in(pen), .periph_drive_in(pdrv),
		.periph_data_in(pdat), .periph_in_only_in(parallel_io), .periph_rx_out(prx),
		.change_irq_out(irq));
	sio_pin_model pads (.clk_in(clk_in), .out_in(pin_o), .oe_in(pin_oe), .pu_in(pu_o),
		.pd_in(pd_o), .ext_in(ext), .ext_en_in(ext_en), .level_out(pin_lvl));

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Gap cycle after each strobe so no signal is set twice in a step
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_in);
		reg_wr <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		@(negedge clk_in);
		chk(reg_rdata, exp);
		@(posedge clk_in);
	endtask
	task automatic irq_count(input int exp);
		n = 0;
		repeat (6) begin
			@(negedge clk_in);
			if (irq === 1'b1)
				n++;
		end
		chk(16'(n), 16'(exp));
		@(posedge clk_in);
	endtask
	function automatic logic [15:0] rnd();
		return 16'($random(seed));
	endfunction
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			test_done;
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 6;
		{fail_count, n_compared, cyc} = '0;
		rst_in = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{pen, pdrv, pdat, parallel_io, ext} = '0;
		ext_en = 16'hffff;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		@(negedge clk_in);
		chk(pin_oe, 16'h0000);
		@(posedge clk_in);
		rdc(OFS_DIR, IMP);
		rdc(OFS_LATCH, 16'h0000);
		rdc(4'hf, 16'h0000);
		$display("reset test done");

		for (int k = 0; k < 10; k++) begin
			an = rnd() & IMP;
			dir = rnd() | an;
			lat = rnd();
			od = (k < 5) ? rnd() : 16'h0000;
			pu = rnd() & dir;
			pd = rnd();
			ext <= rnd();
			if (k >= 5) begin
				pen <= rnd();
				pdrv <= rnd();
				pdat <= rnd();
				parallel_io <= rnd();
			end
			wr(OFS_ANALOG, an);
			wr(OFS_DIR, dir);
			wr(OFS_LATCH, lat);
			wr(OFS_ODRAIN, od);
			wr(OFS_PULLUP, pu);
			wr(OFS_PULLDN, pd);
			repeat (4) @(posedge clk_in);
			@(negedge clk_in);
			own = pen & pdrv & ~parallel_io;
			xoe = own | (~dir & ~(od & lat));
			v = own & pdat | ~own & lat & ~od;
			xpin = xoe & v | ~xoe & ext;
			chk(pin_oe & IMP, xoe & IMP);
			chk(pin_o & xoe & IMP, v & xoe & IMP);
			chk(prx & IMP, xpin & ~(~own & ~dir) & ~an & IMP);
			chk(pu_o & IMP, pu & IMP);
			chk(pd_o & IMP, pd & IMP);
			@(posedge clk_in);
			rdc(OFS_ODRAIN, od);
			rdc(OFS_ANALOG, an);
			rdc(OFS_LEVEL, xpin & ~an & IMP);
			rdc(OFS_DIR, dir & IMP);
			rdc(OFS_LATCH, lat & IMP);
			v = rnd();
			wr(OFS_LEVEL, v);
			rdc(OFS_LATCH, v & IMP);
		end
		$display("random port test done");

		{pen, pdrv, parallel_io} <= '0;
		ext <= 16'h0000;
		wr(OFS_ANALOG, 16'h0000);
		wr(OFS_DIR, 16'hffff);
		wr(OFS_PULLDN, 16'h0000);
		wr(OFS_PULLUP, 16'h0001);
		wr(OFS_CN_EN, 16'h0001);
		repeat (4) @(posedge clk_in);
		wr(OFS_CN_STAT, 16'h0001);
		rdc(OFS_CN_STAT, 16'h0000);
		// Release bit 0 so the pull-up raises it
		ext_en <= 16'hfffe;
		irq_count(1);
		rdc(OFS_CN_STAT, 16'h0001);
		ext <= 16'h0020;
		irq_count(0);
		wr(OFS_CN_STAT, 16'h0001);
		rdc(OFS_CN_STAT, 16'h0000);
		$display("change notify test done");

		rst_in <= 1'b1;
		@(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		rdc(OFS_DIR, IMP);
		$display("second reset test done");
		test_done;
	end
endmodule
